// [design/spo_protect.sv]
// sector protection and otp region control with apb register access
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module spo_protect #(
  parameter int unsigned NSECT        = 256,
  parameter int unsigned SECT_W       = 8,
  parameter int unsigned PROG_CYC     = spo_pkg::NV_PROG_CYC,
  parameter int unsigned ERASE_CYC    = spo_pkg::NV_ERASE_CYC,
  // hidden password, arbitrary value
  parameter logic [63:0] HIDDEN_PW    = 64'h0123_4567_89ab_cdef
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  srst,
  // register bus
  input  wire spo_pkg::spo_apb_req_t apbReq,
  output spo_pkg::spo_apb_rsp_t      apbRsp,
  // array program/erase gating
  input  wire logic [SECT_W-1:0]     arraySector,
  output logic                       arrayGuarded
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [SECT_W-1:0] secOf(input logic [15:0] a);
    secOf = a[SECT_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]                   addr_q;
  logic [15:0]                   wdata_q;
  logic [63:0]                   pw_q;
  logic [15:0]                   vcfg_q;
  logic [15:0]                   rdata_q;
  logic                          fail_q;
  logic                          lock_q;
  logic                          abort_q;
  logic [SECT_W-1:0]             opSec_q;
  logic [15:0]                   timer_q;
  logic [1:0]                    pcfg_q = spo_pkg::PCFG_BOOT_TEMP;
  logic [NSECT-1:0]              nvGuard_q = '1;
  logic [NSECT-1:0]              volGuard_q;
  spo_pkg::spo_ovl_t             ovl_q;
  spo_pkg::spo_state_t           state_q;
  spo_pkg::spo_apb_rsp_t         rsp_q;
  logic                          guarded_q;

  logic                          setup;
  logic                          access;
  logic                          wrAcc;
  logic                          mapped;
  logic                          cmdGo;
  spo_pkg::spo_cmd_t             cmd;
  logic                          pwMode;
  logic                          opEnd;
  logic [31:0]                   rdMux;
  spo_pkg::spo_otp_wr_t          otpWr;
  logic [15:0]                   otpRdata;

  assign apbRsp       = rsp_q;
  assign arrayGuarded = guarded_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign setup  = apbReq.psel && !apbReq.penable;
  assign access = apbReq.psel && apbReq.penable && rsp_q.pready;
  assign wrAcc  = access && apbReq.pwrite && !rsp_q.pslverr;
  assign mapped = hit(apbReq.paddr, spo_pkg::OFS_CMD)    || hit(apbReq.paddr, spo_pkg::OFS_ADDR)  ||
                  hit(apbReq.paddr, spo_pkg::OFS_WDATA)  || hit(apbReq.paddr, spo_pkg::OFS_PWLO)  ||
                  hit(apbReq.paddr, spo_pkg::OFS_PWHI)   || hit(apbReq.paddr, spo_pkg::OFS_STATUS) ||
                  hit(apbReq.paddr, spo_pkg::OFS_VCFG)   || hit(apbReq.paddr, spo_pkg::OFS_RDATA);
  assign cmd    = spo_pkg::spo_cmd_t'(apbReq.pwdata[4:0]);
  assign cmdGo  = wrAcc && hit(apbReq.paddr, spo_pkg::OFS_CMD) && (state_q == spo_pkg::S_IDLE);
  assign pwMode = (pcfg_q == spo_pkg::PCFG_PASSWORD);
  assign opEnd  = (state_q != spo_pkg::S_IDLE) && (timer_q == 16'h0000);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hit(apbReq.paddr, spo_pkg::OFS_ADDR)) begin
      rdMux[15:0] = addr_q;
    end else if (hit(apbReq.paddr, spo_pkg::OFS_WDATA)) begin
      rdMux[15:0] = wdata_q;
    end else if (hit(apbReq.paddr, spo_pkg::OFS_VCFG)) begin
      rdMux[15:0] = vcfg_q;
    end else if (hit(apbReq.paddr, spo_pkg::OFS_RDATA)) begin
      rdMux[15:0] = rdata_q;
    end else if (hit(apbReq.paddr, spo_pkg::OFS_STATUS)) begin
      rdMux[spo_pkg::ST_BUSY]                     = (state_q != spo_pkg::S_IDLE);
      rdMux[spo_pkg::ST_FAIL]                     = fail_q;
      rdMux[spo_pkg::ST_LOCK]                     = lock_q;
      rdMux[spo_pkg::ST_OVL_LSB +: 2]             = ovl_q;
      rdMux[spo_pkg::ST_PWMODE]                   = pwMode;
      rdMux[spo_pkg::ST_PCFG_LSB +: 2]            = pcfg_q;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: ready in every access phase, also while busy
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready  <= setup;
      rsp_q.pslverr <= setup && !mapped;
      if (setup && !apbReq.pwrite) begin
        rsp_q.prdata <= rdMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
      pw_q    <= 64'h0000_0000_0000_0000;
      vcfg_q  <= spo_pkg::VCFG_RESET;
    end else if (wrAcc) begin
      if (hit(apbReq.paddr, spo_pkg::OFS_ADDR)) begin
        addr_q <= apbReq.pwdata[15:0];
      end
      if (hit(apbReq.paddr, spo_pkg::OFS_WDATA)) begin
        wdata_q <= apbReq.pwdata[15:0];
      end
      if (hit(apbReq.paddr, spo_pkg::OFS_PWLO)) begin
        pw_q[31:0] <= apbReq.pwdata;
      end
      if (hit(apbReq.paddr, spo_pkg::OFS_PWHI)) begin
        pw_q[63:32] <= apbReq.pwdata;
      end
      if (hit(apbReq.paddr, spo_pkg::OFS_VCFG)) begin
        vcfg_q <= apbReq.pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // method configuration bits: one-time, frozen once programmed
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (cmdGo && cmd == spo_pkg::CMD_CFG_PROG && pcfg_q == spo_pkg::PCFG_BOOT_TEMP &&
        wdata_q[spo_pkg::PCFG_LSB +: 2] != spo_pkg::PCFG_ILLEGAL) begin
      pcfg_q <= wdata_q[spo_pkg::PCFG_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // guard lock bit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      lock_q <= !pwMode;
    end else if (cmdGo) begin
      if (cmd == spo_pkg::CMD_LOCK_CLR) begin
        lock_q <= 1'b0;
      end else if (cmd == spo_pkg::CMD_PW_UNLOCK && pwMode && pw_q == HIDDEN_PW) begin
        lock_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // address space overlay
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      ovl_q <= spo_pkg::OVL_ARRAY;
    end else if (cmdGo) begin
      unique case (cmd)
        spo_pkg::CMD_OTP_ENTER:   ovl_q <= spo_pkg::OVL_OTP;
        spo_pkg::CMD_GUARD_ENTER: ovl_q <= spo_pkg::OVL_GUARD;
        spo_pkg::CMD_OTP_EXIT:    ovl_q <= spo_pkg::OVL_ARRAY;
        spo_pkg::CMD_GUARD_EXIT:  ovl_q <= spo_pkg::OVL_ARRAY;
        spo_pkg::CMD_SW_RESET:    ovl_q <= spo_pkg::OVL_ARRAY;
        default:                  ovl_q <= ovl_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // otp programming: freeze and region locks only
  // ----------------------------------------------------------------
  always_comb begin
    otpWr.en   = cmdGo && cmd == spo_pkg::CMD_OTP_PROG && ovl_q == spo_pkg::OVL_OTP &&
                 vcfg_q[spo_pkg::VCFG_FREEZE_BIT];
    otpWr.addr = addr_q[spo_pkg::OTP_AW-1:0];
    otpWr.data = wdata_q;
  end

  spo_otp_store u_otp (
    .mclk  (mclk),
    .wr    (otpWr),
    .raddr (addr_q[spo_pkg::OTP_AW-1:0]),
    .rdata (otpRdata)
  );

  // ----------------------------------------------------------------
  // nonvolatile guard operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= spo_pkg::S_IDLE;
      timer_q <= 16'h0000;
      abort_q <= 1'b0;
      opSec_q <= '0;
    end else begin
      unique case (state_q)
        spo_pkg::S_IDLE: begin
          if (cmdGo && ovl_q == spo_pkg::OVL_GUARD && cmd == spo_pkg::CMD_NV_PROG) begin
            state_q <= spo_pkg::S_NVPROG;
            timer_q <= 16'(PROG_CYC - 1);
            abort_q <= !lock_q;
            opSec_q <= secOf(addr_q);
          end else if (cmdGo && ovl_q == spo_pkg::OVL_GUARD && cmd == spo_pkg::CMD_NV_ERASE) begin
            state_q <= lock_q ? spo_pkg::S_PREPROG : spo_pkg::S_NVERASE;
            timer_q <= lock_q ? 16'(PROG_CYC - 1) : 16'(ERASE_CYC - 1);
            abort_q <= !lock_q;
          end
        end
        spo_pkg::S_PREPROG: begin
          if (opEnd) begin
            state_q <= spo_pkg::S_NVERASE;
            timer_q <= 16'(ERASE_CYC - 1);
          end else begin
            timer_q <= timer_q - 16'h0001;
          end
        end
        spo_pkg::S_NVPROG, spo_pkg::S_NVERASE: begin
          if (opEnd) begin
            state_q <= spo_pkg::S_IDLE;
          end else begin
            timer_q <= timer_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile guards: no reset, survive hardware reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (opEnd && !abort_q) begin
      unique case (state_q)
        spo_pkg::S_NVPROG:  nvGuard_q[opSec_q] <= 1'b0;
        spo_pkg::S_PREPROG: nvGuard_q <= '0;
        spo_pkg::S_NVERASE: nvGuard_q <= '1;
        default:            nvGuard_q <= nvGuard_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // failure flag: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      fail_q <= 1'b0;
    end else if (opEnd && abort_q && state_q != spo_pkg::S_PREPROG) begin
      fail_q <= 1'b1;
    end else if (cmdGo && (cmd == spo_pkg::CMD_STAT_CLR || cmd == spo_pkg::CMD_SW_RESET)) begin
      fail_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // volatile guards
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      volGuard_q <= '1;
    end else if (cmdGo && cmd == spo_pkg::CMD_VOL_SET) begin
      volGuard_q[secOf(addr_q)] <= 1'b0;
    end else if (cmdGo && cmd == spo_pkg::CMD_VOL_CLR) begin
      volGuard_q[secOf(addr_q)] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read results
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else if (cmdGo) begin
      if (cmd == spo_pkg::CMD_OTP_READ && ovl_q == spo_pkg::OVL_OTP) begin
        rdata_q <= otpRdata;
      end else if (cmd == spo_pkg::CMD_NV_READ && ovl_q == spo_pkg::OVL_GUARD) begin
        rdata_q <= {15'h0000, nvGuard_q[secOf(addr_q)]};
      end else if (cmd == spo_pkg::CMD_VOL_READ) begin
        rdata_q <= {15'h0000, volGuard_q[secOf(addr_q)]};
      end
    end
  end

  // ----------------------------------------------------------------
  // array sector gating
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      guarded_q <= 1'b0;
    end else begin
      guarded_q <= !(nvGuard_q[arraySector] && volGuard_q[arraySector]);
    end
  end

endmodule
`default_nettype wire

// [design/spo_pkg.sv]
// shared constants and types of the sector protection and otp region block
package spo_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_PWLO   = 8'h0c;
  localparam logic [7:0] OFS_PWHI   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_VCFG   = 8'h18;
  localparam logic [7:0] OFS_RDATA  = 8'h1c;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned   VCFG_FREEZE_BIT = 10;
  localparam logic [15:0]   VCFG_RESET      = 16'hffff;
  localparam int unsigned   ST_BUSY         = 0;
  localparam int unsigned   ST_FAIL         = 1;
  localparam int unsigned   ST_LOCK         = 2;
  localparam int unsigned   ST_OVL_LSB      = 3;
  localparam int unsigned   ST_PWMODE       = 5;
  localparam int unsigned   ST_PCFG_LSB     = 6;
  localparam int unsigned   PCFG_LSB        = 1;

  // ----------------------------------------------------------------
  // method-lock configuration codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PCFG_ILLEGAL   = 2'h0;
  localparam logic [1:0] PCFG_PASSWORD  = 2'h1;
  localparam logic [1:0] PCFG_BOOT_PERM = 2'h2;
  localparam logic [1:0] PCFG_BOOT_TEMP = 2'h3;

  // ----------------------------------------------------------------
  // otp region layout (16-bit words)
  // ----------------------------------------------------------------
  localparam int unsigned OTP_AW         = 9;
  localparam int unsigned OTP_REGION_LSB = 4;
  localparam logic [8:0]  OTP_LOCK_W0    = 9'h008;
  localparam logic [8:0]  OTP_LOCK_W1    = 9'h009;
  localparam logic [15:0] OTP_ERASED     = 16'hffff;

  // ----------------------------------------------------------------
  // timing counts in mclk cycles
  // ----------------------------------------------------------------
  localparam int unsigned NV_PROG_CYC  = 16;
  localparam int unsigned NV_ERASE_CYC = 64;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_NOP, CMD_OTP_ENTER, CMD_OTP_EXIT, CMD_OTP_PROG, CMD_OTP_READ,
    CMD_GUARD_ENTER, CMD_GUARD_EXIT, CMD_NV_PROG, CMD_NV_ERASE, CMD_NV_READ,
    CMD_VOL_SET, CMD_VOL_CLR, CMD_VOL_READ, CMD_LOCK_CLR, CMD_PW_UNLOCK,
    CMD_SW_RESET, CMD_CFG_PROG, CMD_STAT_CLR
  } spo_cmd_t;

  typedef enum logic [1:0] {OVL_ARRAY, OVL_OTP, OVL_GUARD} spo_ovl_t;

  typedef enum logic [1:0] {S_IDLE, S_NVPROG, S_PREPROG, S_NVERASE} spo_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spo_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spo_apb_rsp_t;

  typedef struct packed {
    logic        en;
    logic [8:0]  addr;
    logic [15:0] data;
  } spo_otp_wr_t;

endpackage

// [design/spo_otp_store.sv]
// one-time programmable secure region storage with per-region lock bits
`timescale 1ns/100ps
`default_nettype none
module spo_otp_store (
  // clock
  input  wire logic                        mclk,
  // program port
  input  wire spo_pkg::spo_otp_wr_t        wr,
  // read port
  input  wire logic [spo_pkg::OTP_AW-1:0]  raddr,
  output logic      [15:0]                 rdata
);

  // ----------------------------------------------------------------
  // storage, delivered erased
  // ----------------------------------------------------------------
  logic [15:0] mem [0:(1<<spo_pkg::OTP_AW)-1] = '{default: spo_pkg::OTP_ERASED};
  logic [31:0] lockWord;
  logic [4:0]  region;

  assign lockWord = {mem[spo_pkg::OTP_LOCK_W1], mem[spo_pkg::OTP_LOCK_W0]};
  assign region   = wr.addr[spo_pkg::OTP_AW-1:spo_pkg::OTP_REGION_LSB];

  // ----------------------------------------------------------------
  // program only clears bits; repeats allowed, no erase path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wr.en && lockWord[region]) begin
      mem[wr.addr] <= mem[wr.addr] & wr.data;
    end
  end

  assign rdata = mem[raddr];

endmodule
`default_nettype wire

// [bench/spo_host_model.sv]
// host controller model: apb master issuing register transfers
`timescale 1ns/100ps
`default_nettype none
module spo_host_model (
  // clock
  input  wire logic                  mclk,
  // register bus
  output var  spo_pkg::spo_apb_req_t apbReq,
  input  wire spo_pkg::spo_apb_rsp_t apbRsp
);
  initial apbReq = '0;

  // ----------------------------------------------------------------
  // one transfer: setup, then access held until pready
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do @(posedge mclk); while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/spo_protect_props.sv]
// bus and gating checks bound to the protection block
`timescale 1ns/100ps
`default_nettype none
module spo_protect_props #(
  parameter int unsigned SECT_W = 8
) (
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  srst,
  // register bus
  input wire spo_pkg::spo_apb_req_t apbReq,
  input wire spo_pkg::spo_apb_rsp_t apbRsp,
  // array gating
  input wire logic [SECT_W-1:0]     arraySector,
  input wire logic                  arrayGuarded
);
  logic setup;
  logic mapped;
  assign setup  = apbReq.psel && !apbReq.penable;
  assign mapped = apbReq.paddr[1:0] == 2'h0 && apbReq.paddr <= spo_pkg::OFS_RDATA;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  a_ready_after_setup: assert property (setup |=> apbRsp.pready)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (apbRsp.pready |-> apbReq.psel && apbReq.penable)
    else $error("pready outside access phase");
  a_ready_one_cycle: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (setup && !mapped |=> apbRsp.pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (setup && mapped |=> !apbRsp.pslverr)
    else $error("error on mapped address");
  a_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("pslverr without pready");
  a_rdata_hold: assert property (!(setup && !apbReq.pwrite) |=> $stable(apbRsp.prdata))
    else $error("prdata changed without read");
  a_rdata_upper_zero: assert property (apbRsp.pready && !apbReq.pwrite && mapped
      && apbReq.paddr != spo_pkg::OFS_PWLO && apbReq.paddr != spo_pkg::OFS_PWHI
      |-> apbRsp.prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_guard_reset_low: assert property (@(posedge mclk) disable iff (1'b0) srst |=> !arrayGuarded)
    else $error("arrayGuarded high after reset");
endmodule

bind spo_protect spo_protect_props #(.SECT_W(SECT_W)) spo_protect_props_inst (
  .mclk(mclk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
  .arraySector(arraySector), .arrayGuarded(arrayGuarded));
`default_nettype wire

// [bench/spo_protect_test.sv]
// self-checking testbench of the protection block
`timescale 1ns/100ps
`default_nettype none
module spo_protect_test;
  logic                  mclk;
  logic                  srst;
  logic [7:0]            arraySector;
  logic                  arrayGuarded;
  spo_pkg::spo_apb_req_t apbReq;
  spo_pkg::spo_apb_rsp_t apbRsp;
  logic [31:0]           q;
  logic                  e;
  int                    errCount = 0;
  int                    cmpCount = 0;

  spo_protect #(.PROG_CYC(2), .ERASE_CYC(4)) spo_protect_inst (.mclk(mclk), .srst(srst),
    .apbReq(apbReq), .apbRsp(apbRsp), .arraySector(arraySector), .arrayGuarded(arrayGuarded));
  spo_host_model spo_host_model_inst (.mclk(mclk), .apbReq(apbReq), .apbRsp(apbRsp));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmpCount++;
    if (g !== x) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    spo_host_model_inst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    spo_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic cmd(input spo_pkg::spo_cmd_t c);
    wr(spo_pkg::OFS_CMD, {27'h0, c});
  endtask
  task automatic cmdAt(input logic [15:0] a, input spo_pkg::spo_cmd_t c);
    wr(spo_pkg::OFS_ADDR, {16'h0, a});
    cmd(c);
  endtask
  task automatic stat(input logic [7:0] x);
    rd(spo_pkg::OFS_STATUS);
    chk("status", {24'h0, x}, q);
  endtask
  task automatic rdData(input spo_pkg::spo_cmd_t c, input logic [15:0] x);
    cmd(c);
    rd(spo_pkg::OFS_RDATA);
    chk("rdata", {16'h0, x}, q);
  endtask
  task automatic otpProg(input logic [15:0] a, input logic [15:0] d);
    wr(spo_pkg::OFS_WDATA, {16'h0, d});
    cmdAt(a, spo_pkg::CMD_OTP_PROG);
  endtask
  task automatic otpRead(input logic [15:0] a, input logic [15:0] x);
    wr(spo_pkg::OFS_ADDR, {16'h0, a});
    rdData(spo_pkg::CMD_OTP_READ, x);
  endtask
  task automatic guardAt(input logic [7:0] s, input logic x);
    arraySector <= s;
    repeat (2) @(posedge mclk);
    chk("arrayGuarded", {31'h0, x}, {31'h0, arrayGuarded});
  endtask
  task automatic waitIdle;
    rd(spo_pkg::OFS_STATUS);
    for (int i = 0; i < 100 && q[spo_pkg::ST_BUSY] !== 1'b0; i++) rd(spo_pkg::OFS_STATUS);
    chk("busy", 32'h0, {31'h0, q[spo_pkg::ST_BUSY]});
  endtask
  task automatic hwReset;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task automatic tallyAndFinish;
    if (errCount == 0 && cmpCount > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    tallyAndFinish();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    arraySector = 8'h00;
    hwReset();
    stat(8'hc4);
    rd(spo_pkg::OFS_VCFG);
    chk("vcfg", 32'h0000ffff, q);
    rd(8'h40);
    chk("pslverr", 32'h1, {31'h0, e});
    cmd(spo_pkg::CMD_OTP_ENTER);
    stat(8'hcc);
    otpProg(16'h0220, 16'h1234);
    otpRead(16'h0020, 16'h1234);
    otpProg(16'h0020, 16'h00ff);
    otpRead(16'h0020, 16'h0034);
    otpRead(16'h000a, 16'hffff);
    otpProg(16'h0008, 16'hfffb);
    otpProg(16'h0020, 16'h0000);
    otpRead(16'h0020, 16'h0034);
    wr(spo_pkg::OFS_VCFG, 32'h0000fbff);
    otpProg(16'h0030, 16'h0000);
    otpRead(16'h0030, 16'hffff);
    stat(8'hcc);
    cmd(spo_pkg::CMD_OTP_EXIT);
    stat(8'hc4);
    guardAt(8'h09, 1'b0);
    cmdAt(16'h0007, spo_pkg::CMD_VOL_SET);
    guardAt(8'h07, 1'b1);
    rdData(spo_pkg::CMD_VOL_READ, 16'h0000);
    cmdAt(16'h0007, spo_pkg::CMD_VOL_CLR);
    guardAt(8'h07, 1'b0);
    cmd(spo_pkg::CMD_GUARD_ENTER);
    cmdAt(16'h0009, spo_pkg::CMD_NV_PROG);
    waitIdle();
    rdData(spo_pkg::CMD_NV_READ, 16'h0000);
    guardAt(8'h09, 1'b1);
    cmd(spo_pkg::CMD_NV_ERASE);
    waitIdle();
    rdData(spo_pkg::CMD_NV_READ, 16'h0001);
    cmd(spo_pkg::CMD_LOCK_CLR);
    stat(8'hd0);
    cmd(spo_pkg::CMD_NV_PROG);
    waitIdle();
    stat(8'hd2);
    rdData(spo_pkg::CMD_NV_READ, 16'h0001);
    cmd(spo_pkg::CMD_PW_UNLOCK);
    stat(8'hd2);
    cmd(spo_pkg::CMD_SW_RESET);
    stat(8'hc0);
    hwReset();
    stat(8'hc4);
    wr(spo_pkg::OFS_WDATA, 32'h00000002);
    cmd(spo_pkg::CMD_CFG_PROG);
    hwReset();
    stat(8'h60);
    cmd(spo_pkg::CMD_GUARD_ENTER);
    wr(spo_pkg::OFS_PWHI, 32'h01234567);
    wr(spo_pkg::OFS_PWLO, 32'h89abcdee);
    cmd(spo_pkg::CMD_PW_UNLOCK);
    stat(8'h70);
    wr(spo_pkg::OFS_PWLO, 32'h89abcdef);
    cmd(spo_pkg::CMD_PW_UNLOCK);
    stat(8'h74);
    cmdAt(16'h0005, spo_pkg::CMD_NV_PROG);
    waitIdle();
    guardAt(8'h05, 1'b1);
    cmd(spo_pkg::CMD_LOCK_CLR);
    stat(8'h70);
    cmd(spo_pkg::CMD_NV_ERASE);
    waitIdle();
    stat(8'h72);
    rdData(spo_pkg::CMD_NV_READ, 16'h0000);
    cmd(spo_pkg::CMD_STAT_CLR);
    stat(8'h70);
    cmd(spo_pkg::CMD_GUARD_EXIT);
    stat(8'h60);
    cmd(spo_pkg::CMD_SW_RESET);
    wr(spo_pkg::OFS_WDATA, 32'h00000004);
    cmd(spo_pkg::CMD_CFG_PROG);
    stat(8'h60);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
